//--- design/dcsf_top.sv
// Behaviour
// RULE_01: write clock rise with enable stores word
// RULE_02: read clock rise with enable advances read
// RULE_03: both clocks independent, any rate
// RULE_04: standard mode: data shows only after read
// RULE_05: fall through: first word after three transitions
// RULE_06: mode pin level during master reset chooses mode
// RULE_07: flag pins change meaning with mode
// RULE_08: offset load pin picks 127 parallel, 1023 serial
// RULE_09: serial enable and load shift offset bit
// RULE_10: write enable and load load offset word
// RULE_11: read enable and load show offsets
// RULE_12: master reset clears pointers, latches mode, flags
// RULE_13: partial reset clears pointers, keeps settings
// RULE_14: reread request sets read pointer first
// RULE_15: almost flags use independent offsets
// RULE_16: idle device enters standby, leaves immediately
// RULE_17: fall through chains without glue logic
// RULE_18: output enable tristates data independently
// RULE_19: nine bits wide, 16384 words deep
// RULE_20: master reset zeroes the output register
// RULE_21: reread keeps settings, pulses empty flag
// RULE_22: writes ignored when full, reads when empty
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
module dcsf_top (
   // clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   resetn_i,
   // fifo pins
   input  wire dcsf_pkg::dcsf_pins_t   pins_i,
   output var  logic [8:0]             data_out_bus_o,
   output var  logic                   data_out_oe_n_o,
   output var  dcsf_pkg::dcsf_flags_t  flags_o,
   output var  logic                   standby_o,
   // avalon register slave
   input  wire dcsf_pkg::dcsf_avm_req_t avm_req_i,
   output var  dcsf_pkg::dcsf_avm_rsp_t avm_rsp_o
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      dcsf_pkg::dcsf_pins_t   p1;
      dcsf_pkg::dcsf_pins_t   p2;
      logic                   wclk_d;
      logic                   rclk_d;
      logic [14:0]            wptr;
      logic [14:0]            rptr;
      logic                   fall_through_mode;
      logic                   serial_mode;
      logic [14:0]            ae_off;
      logic [14:0]            af_off;
      logic [1:0]             wsel;
      logic [1:0]             rsel;
      logic [8:0]             dout;
      logic                   dout_oe_n;
      dcsf_pkg::dcsf_ft_t     ft;
      logic [1:0]             ft_cnt;
      logic                   rt_blank;
      dcsf_pkg::dcsf_flags_t  flags;
      logic                   standby;
      dcsf_pkg::dcsf_avm_rsp_t rsp;
   } dcsf_state_t;

   dcsf_state_t s;
   dcsf_state_t next_s;

   logic [8:0]  mem [dcsf_pkg::DEPTH];    // [RULE_19]
   logic        do_write;
   logic [8:0]  rd_word;
   logic [14:0] cnt;
   logic [14:0] next_cnt;
   logic        wrise;
   logic        rrise;
   logic        rfall;
   logic        run;
   logic        bus_take;

   // ************************************************************
   // pin timing and occupancy
   // ************************************************************
   // clocks are plain inputs sampled by clk_i, so each may stop or run at any ratio
   assign wrise    = s.p2.wclk & ~s.wclk_d;                      // [RULE_03]
   assign rrise    = s.p2.rclk & ~s.rclk_d;
   assign rfall    = ~s.p2.rclk & s.rclk_d;
   assign run      = s.p2.master_reset_n & s.p2.partial_reset_n;
   assign cnt      = s.wptr - s.rptr;
   assign rd_word  = mem[s.rptr[dcsf_pkg::ADDR_W-1:0]];
   assign bus_take = (avm_req_i.read | avm_req_i.write) & ~s.rsp.waitrequest;

   // ************************************************************
   // next state
   // ************************************************************
   // a single process keeps write, read, reset and bus priorities in one place
   always_comb begin
      next_s        = s;
      do_write      = 1'b0;
      next_s.p1     = pins_i;
      next_s.p2     = s.p1;
      next_s.wclk_d = s.p2.wclk;
      next_s.rclk_d = s.p2.rclk;
      if (!s.p2.master_reset_n) begin
         // settings follow the pins for as long as master reset is held
         next_s.wptr              = dcsf_pkg::PTR_FIRST;                  // [RULE_12]
         next_s.rptr              = dcsf_pkg::PTR_FIRST;
         next_s.dout              = '0;                                  // [RULE_20]
         next_s.fall_through_mode = s.p2.mode_select_serial_in;          // [RULE_06]
         next_s.serial_mode       = s.p2.offset_load_select_n;           // [RULE_08]
         next_s.ae_off = s.p2.offset_load_select_n ? dcsf_pkg::OFF_DEF_SER
                                                   : dcsf_pkg::OFF_DEF_PAR;
         next_s.af_off = next_s.ae_off;
         next_s.wsel     = '0;
         next_s.rsel     = '0;
         next_s.ft       = dcsf_pkg::DCSF_FT_IDLE;
         next_s.ft_cnt   = '0;
         next_s.rt_blank = 1'b0;
      end else if (!s.p2.partial_reset_n) begin
         // mode, method and offsets stay as they were
         next_s.wptr     = dcsf_pkg::PTR_FIRST;                          // [RULE_13]
         next_s.rptr     = dcsf_pkg::PTR_FIRST;
         next_s.wsel     = '0;
         next_s.rsel     = '0;
         next_s.ft       = dcsf_pkg::DCSF_FT_IDLE;
         next_s.ft_cnt   = '0;
         next_s.rt_blank = 1'b0;
      end else begin
         // write side
         if (wrise && !s.p2.offset_load_select_n) begin
            if (s.serial_mode && !s.p2.serial_load_enable_n) begin
               // lsb of almost empty first, almost full last
               {next_s.af_off, next_s.ae_off} =
                  {s.p2.mode_select_serial_in, s.af_off, s.ae_off[14:1]}; // [RULE_09]
            end else if (!s.serial_mode && !s.p2.wen_n) begin
               case (s.wsel)                                             // [RULE_10]
                  dcsf_pkg::SEL_AE_LO: next_s.ae_off[8:0]  = s.p2.data_in_bus;
                  dcsf_pkg::SEL_AE_HI: next_s.ae_off[14:9] = s.p2.data_in_bus[5:0];
                  dcsf_pkg::SEL_AF_LO: next_s.af_off[8:0]  = s.p2.data_in_bus;
                  default:             next_s.af_off[14:9] = s.p2.data_in_bus[5:0];
               endcase
               next_s.wsel = s.wsel + dcsf_pkg::SEL_ONE;
            end
         end else if (wrise && !s.p2.wen_n && cnt != dcsf_pkg::DEPTH_CNT) begin
            do_write    = 1'b1;                                          // [RULE_01] [RULE_22]
            next_s.wptr = s.wptr + dcsf_pkg::PTR_ONE;
         end
         // read side
         if (rrise && !s.p2.reread_request_n) begin
            // write pointer and all settings are left alone
            next_s.rptr     = dcsf_pkg::PTR_FIRST;                       // [RULE_14] [RULE_21]
            next_s.ft       = dcsf_pkg::DCSF_FT_IDLE;
            next_s.ft_cnt   = '0;
            next_s.rt_blank = 1'b1;
         end else if (rrise && !s.p2.ren_n && !s.p2.offset_load_select_n) begin
            case (s.rsel)                                                // [RULE_11]
               dcsf_pkg::SEL_AE_LO: next_s.dout = s.ae_off[8:0];
               dcsf_pkg::SEL_AE_HI: next_s.dout = {3'h0, s.ae_off[14:9]};
               dcsf_pkg::SEL_AF_LO: next_s.dout = s.af_off[8:0];
               default:             next_s.dout = {3'h0, s.af_off[14:9]};
            endcase
            next_s.rsel = s.rsel + dcsf_pkg::SEL_ONE;
         end else begin
            if (rrise)
               next_s.rt_blank = 1'b0;
            if (!s.fall_through_mode) begin
               // word leaves memory only on a read
               if (rrise && !s.p2.ren_n && cnt != '0) begin                // [RULE_04] [RULE_22]
                  next_s.dout = rd_word;                                 // [RULE_02]
                  next_s.rptr = s.rptr + dcsf_pkg::PTR_ONE;
               end
            end else begin
               case (s.ft)
                  dcsf_pkg::DCSF_FT_IDLE: begin
                     if (cnt != '0) begin
                        next_s.ft     = dcsf_pkg::DCSF_FT_WAIT;
                        next_s.ft_cnt = '0;
                     end
                  end
                  dcsf_pkg::DCSF_FT_WAIT: begin
                     // first word falls through with no read enable
                     if (rrise || rfall) begin
                        if (s.ft_cnt == dcsf_pkg::FT_EDGES_M1) begin     // [RULE_05]
                           next_s.dout = rd_word;
                           next_s.rptr = s.rptr + dcsf_pkg::PTR_ONE;
                           next_s.ft   = dcsf_pkg::DCSF_FT_VALID;
                        end else begin
                           next_s.ft_cnt = s.ft_cnt + dcsf_pkg::SEL_ONE;
                        end
                     end
                  end
                  dcsf_pkg::DCSF_FT_VALID: begin
                     // later words need read enable; chained parts feed on this
                     if (rrise && !s.p2.ren_n) begin                     // [RULE_17]
                        if (cnt != '0) begin
                           next_s.dout = rd_word;                        // [RULE_02]
                           next_s.rptr = s.rptr + dcsf_pkg::PTR_ONE;
                        end else begin
                           next_s.ft = dcsf_pkg::DCSF_FT_IDLE;
                        end
                     end
                  end
                  default: next_s.ft = dcsf_pkg::DCSF_FT_IDLE;
               endcase
            end
         end
      end
      // software may overwrite both offsets; pins and bus rarely meet
      if (bus_take && avm_req_i.write && avm_req_i.address == dcsf_pkg::REG_OFFSET) begin
         next_s.ae_off = avm_req_i.writedata[dcsf_pkg::OFF_W-1:0];
         next_s.af_off = avm_req_i.writedata[dcsf_pkg::OFF_AF_LSB +: dcsf_pkg::OFF_W];
      end
      // output enable is independent of any read
      next_s.dout_oe_n = s.p2.oe_n;                                      // [RULE_18]
      // flags from the new occupancy
      next_cnt = next_s.wptr - next_s.rptr;
      if (next_s.fall_through_mode) begin                                // [RULE_07]
         next_s.flags.empty_flag_n = next_s.ft != dcsf_pkg::DCSF_FT_VALID;
         next_s.flags.full_flag_n  = next_cnt == dcsf_pkg::DEPTH_CNT;
      end else begin
         next_s.flags.empty_flag_n = next_cnt != '0 && !next_s.rt_blank;
         next_s.flags.full_flag_n  = next_cnt != dcsf_pkg::DEPTH_CNT;
      end
      next_s.flags.half_full_flag_n    = !(next_cnt > dcsf_pkg::HALF_CNT);
      next_s.flags.almost_empty_flag_n = !(next_cnt <= next_s.ae_off);         // [RULE_15]
      next_s.flags.almost_full_flag_n  =
         !(next_cnt >= dcsf_pkg::DEPTH_CNT - next_s.af_off);
      // standby while no rising clock edge, no reset and no enable, serial load or reread is active
      next_s.standby = !wrise && !rrise && run && s.p2.wen_n && s.p2.ren_n   // [RULE_16]
                       && s.p2.serial_load_enable_n && s.p2.reread_request_n;
      // avalon: one wait cycle, then the answer
      next_s.rsp.waitrequest = !((avm_req_i.read || avm_req_i.write) && s.rsp.waitrequest);
      if (avm_req_i.read && s.rsp.waitrequest) begin
         case (avm_req_i.address)
            dcsf_pkg::REG_STATUS: next_s.rsp.readdata = {12'h000, s.flags, cnt};
            dcsf_pkg::REG_OFFSET: next_s.rsp.readdata = {1'b0, s.af_off, 1'b0, s.ae_off};
            dcsf_pkg::REG_CONFIG: next_s.rsp.readdata =
               {29'h0000_0000, s.standby, s.serial_mode, s.fall_through_mode};
            default:              next_s.rsp.readdata = '0;
         endcase
      end
      if (!resetn_i) begin
         next_s                 = '0;
         next_s.rsp.waitrequest = 1'b1;
         next_s.dout_oe_n       = 1'b1;
         next_s.flags           = '1;
         next_s.flags.empty_flag_n = 1'b0;
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk_i) begin
      s <= next_s;
   end

   // memory array, not reset: stale words are never read past the pointers
   always_ff @(posedge clk_i) begin
      if (do_write)
         mem[s.wptr[dcsf_pkg::ADDR_W-1:0]] <= s.p2.data_in_bus;
   end

   assign data_out_bus_o  = s.dout;
   assign data_out_oe_n_o = s.dout_oe_n;
   assign flags_o         = s.flags;
   assign standby_o       = s.standby;
   assign avm_rsp_o       = s.rsp;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   sequence seq_write_go;
      run && wrise && !s.p2.wen_n && s.p2.offset_load_select_n
         && cnt != dcsf_pkg::DEPTH_CNT;
   endsequence
   sequence seq_full_write;
      run && wrise && !s.p2.wen_n && s.p2.offset_load_select_n
         && cnt == dcsf_pkg::DEPTH_CNT;
   endsequence
   sequence seq_std_read;
      run && !s.fall_through_mode && rrise && !s.p2.ren_n && s.p2.reread_request_n
         && s.p2.offset_load_select_n && cnt != '0;
   endsequence

   a_write_advance: assert property (seq_write_go // [RULE_01]
                                     |=> s.wptr == $past(s.wptr) + dcsf_pkg::PTR_ONE)
      else $error("write did not advance the write pointer");
   a_full_ignore: assert property (seq_full_write |=> s.wptr == $past(s.wptr)) // [RULE_22]
      else $error("write taken while full");
   a_read_advance: assert property (seq_std_read // [RULE_02]
                                    |=> s.rptr == $past(s.rptr) + dcsf_pkg::PTR_ONE
                                    && s.dout == $past(rd_word))
      else $error("read did not advance or present the word");
   a_std_hold: assert property (run && !s.fall_through_mode && !rrise // [RULE_04]
                                |=> $stable(s.dout))
      else $error("standard mode output changed without read");
   a_ft_fill: assert property ($rose(s.ft == dcsf_pkg::DCSF_FT_VALID) // [RULE_05]
                               && s.p2.master_reset_n |-> $past(rrise || rfall)
                               && $past(s.ft_cnt) == dcsf_pkg::FT_EDGES_M1)
      else $error("first word fell through on wrong transition");
   a_master_clear: assert property (!s.p2.master_reset_n ##1 !s.p2.master_reset_n // [RULE_12]
                                    |-> s.wptr == '0 && s.rptr == '0 && s.dout == '0)
      else $error("master reset left pointers or output");
   a_partial_keep: assert property (s.p2.master_reset_n && !s.p2.partial_reset_n // [RULE_13]
                                    && !bus_take |=> s.rptr == '0
                                    && $stable(s.fall_through_mode)
                                    && $stable(s.ae_off) && $stable(s.af_off))
      else $error("partial reset disturbed settings");
   a_reread_first: assert property (run && rrise && !s.p2.reread_request_n // [RULE_14]
                                    |=> s.rptr == '0 && $stable(s.serial_mode))
      else $error("reread did not rewind the read pointer");
   a_oe_follow: assert property (s.p2.oe_n ##1 1'b1 |-> s.dout_oe_n) // [RULE_18]
      else $error("output not released by output enable");
   a_bus_answer: assert property ((avm_req_i.read || avm_req_i.write) && avm_rsp_o.waitrequest
                                  |=> !avm_rsp_o.waitrequest)
      else $error("bus request not answered in one cycle");

endmodule

//--- pkg/dcsf_pkg.sv
// ************************************************************
// constants and carriers of the dual clock 9 bit fifo
// ************************************************************
package dcsf_pkg;

   // memory geometry, fixed to the smaller variant
   localparam int          DATA_W     = 9;
   localparam int          DEPTH      = 16384;
   localparam int          ADDR_W     = 14;
   localparam int          PTR_W      = 15;        // one extra bit tells wrap apart
   localparam int          OFF_W      = 15;
   localparam int          OFF_LO_W   = 9;         // low offset part carried on one data word
   localparam int          OFF_HI_W   = OFF_W - OFF_LO_W;
   localparam logic [14:0] DEPTH_CNT  = 15'h4000;
   localparam logic [14:0] HALF_CNT   = 15'h2000;
   localparam logic [14:0] PTR_ONE    = 15'h0001;
   localparam logic [14:0] PTR_FIRST  = 15'h0000;

   // default flag offsets picked by the offset load pin during master reset
   localparam logic [14:0] OFF_DEF_PAR = 15'h007F; // 127, parallel programming
   localparam logic [14:0] OFF_DEF_SER = 15'h03FF; // 1023, serial programming

   // fall through: read clock transitions before the first word shows
   localparam logic [1:0]  FT_EDGES_M1 = 2'h2;
   localparam logic [1:0]  SEL_ONE     = 2'h1;

   // parallel offset word sequence
   localparam logic [1:0]  SEL_AE_LO  = 2'h0;
   localparam logic [1:0]  SEL_AE_HI  = 2'h1;
   localparam logic [1:0]  SEL_AF_LO  = 2'h2;
   localparam logic [1:0]  SEL_AF_HI  = 2'h3;

   // avalon register word addresses and fields
   localparam logic [1:0]  REG_STATUS = 2'h0;
   localparam logic [1:0]  REG_OFFSET = 2'h1;
   localparam logic [1:0]  REG_CONFIG = 2'h2;
   localparam int          OFF_AF_LSB = 16;

   // pin inputs, all asynchronous to clk_i
   typedef struct packed {
      logic              wclk;
      logic              rclk;
      logic              wen_n;
      logic              ren_n;
      logic              serial_load_enable_n;
      logic              offset_load_select_n;
      logic              master_reset_n;
      logic              partial_reset_n;
      logic              reread_request_n;
      logic              oe_n;
      logic              mode_select_serial_in;
      logic [8:0]        data_in_bus;
   } dcsf_pins_t;

   // flag pins, all active low
   typedef struct packed {
      logic empty_flag_n;       // empty (standard) or output ready (fall through)
      logic full_flag_n;        // full (standard) or input space (fall through)
      logic half_full_flag_n;
      logic almost_empty_flag_n;
      logic almost_full_flag_n;
   } dcsf_flags_t;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [1:0]  address;
      logic [31:0] writedata;
   } dcsf_avm_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } dcsf_avm_rsp_t;

   // fall through output stage, gray along fill then hold
   typedef enum logic [1:0] {
      DCSF_FT_IDLE  = 2'b00,
      DCSF_FT_WAIT  = 2'b01,
      DCSF_FT_VALID = 2'b11
   } dcsf_ft_t;

endpackage

//--- test/dcsf_far_end.sv
`timescale 1ns/100ps
// ********************
// producer and consumer on the pin side
// ********************
module dcsf_far_end (
   // system clock
   input  wire logic                 clk_i,
   // pins toward the fifo
   output var  dcsf_pkg::dcsf_pins_t pins_o
);
   // idle levels: controls inactive, clocks low, output driven
   initial begin
      pins_o = '1;
      pins_o.wclk = 1'b0;
      pins_o.rclk = 1'b0;
      pins_o.oe_n = 1'b0;
      pins_o.data_in_bus = 9'h000;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // one pin clock pulse; three edges of margin cover the two flop sampler
   task automatic pin_cycle(input logic rd, input logic en_n, input logic ld_n,
                            input logic aux_n, input logic [8:0] d);
      @(posedge clk_i);
      pins_o.offset_load_select_n <= ld_n;
      if (rd) begin
         pins_o.ren_n <= en_n;
         pins_o.reread_request_n <= aux_n;
      end else begin
         pins_o.wen_n <= en_n;
         pins_o.serial_load_enable_n <= aux_n;
         pins_o.data_in_bus <= d;
         pins_o.mode_select_serial_in <= d[0];
      end
      wait_clk(3);
      if (rd) pins_o.rclk <= 1'b1;
      else pins_o.wclk <= 1'b1;
      wait_clk(3);
      // released data and serial lines show the inverse so a stale value never passes
      pins_o.wen_n <= 1'b1;
      pins_o.ren_n <= 1'b1;
      pins_o.serial_load_enable_n <= 1'b1;
      pins_o.reread_request_n <= 1'b1;
      pins_o.offset_load_select_n <= 1'b1;
      pins_o.data_in_bus <= ~d;
      pins_o.mode_select_serial_in <= ~d[0];
      pins_o.rclk <= 1'b0;
      pins_o.wclk <= 1'b0;
      wait_clk(3);
   endtask

   // strap levels held through the whole reset and past its release
   task automatic master_reset(input logic mode, input logic ld_n);
      @(posedge clk_i);
      pins_o.mode_select_serial_in <= mode;
      pins_o.offset_load_select_n <= ld_n;
      pins_o.master_reset_n <= 1'b0;
      wait_clk(6);
      pins_o.master_reset_n <= 1'b1;
      wait_clk(4);
      pins_o.offset_load_select_n <= 1'b1;
      pins_o.mode_select_serial_in <= ~mode;
      wait_clk(3);
   endtask

   task automatic partial_reset();
      @(posedge clk_i);
      pins_o.partial_reset_n <= 1'b0;
      wait_clk(6);
      pins_o.partial_reset_n <= 1'b1;
      wait_clk(4);
   endtask

   task automatic set_oe(input logic oe_n);
      @(posedge clk_i);
      pins_o.oe_n <= oe_n;
   endtask
endmodule

//--- test/dcsf_top_tb.sv
`timescale 1ns/100ps
// ********************
// self checking bench of the fifo
// ********************
module dcsf_top_tb;
   logic                    clk_i;
   logic                    resetn_i;
   dcsf_pkg::dcsf_pins_t    pins;
   logic [8:0]              dout;
   logic                    dout_oe_n;
   dcsf_pkg::dcsf_flags_t   flags;
   logic                    standby;
   dcsf_pkg::dcsf_avm_req_t avm_req;
   dcsf_pkg::dcsf_avm_rsp_t avm_rsp;
   int                      num_errors = 0;
   int                      cmp_count = 0;
   int                      seed = 8;
   int                      i;
   logic [31:0]             rd;
   logic [31:0]             v;
   logic [8:0]              q[$];
   logic [8:0]              w[4];
   logic [8:0]              exp_off[4];

   dcsf_top dcsf_top_inst (.clk_i(clk_i), .resetn_i(resetn_i), .pins_i(pins),
      .data_out_bus_o(dout), .data_out_oe_n_o(dout_oe_n), .flags_o(flags),
      .standby_o(standby), .avm_req_i(avm_req), .avm_rsp_o(avm_rsp));
   dcsf_far_end dcsf_far_end_inst (.clk_i(clk_i), .pins_o(pins));

   // free running system clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [31:0] off_word(input logic [14:0] ae, input logic [14:0] af);
      return {1'b0, af, 1'b0, ae};
   endfunction

   // request stands until waitrequest is sampled low at a rising edge, data taken there
   task automatic avm(input logic wr, input logic [1:0] a, input logic [31:0] wd);
      @(posedge clk_i);
      avm_req.read <= ~wr;
      avm_req.write <= wr;
      avm_req.address <= a;
      avm_req.writedata <= wd;
      do @(posedge clk_i); while (avm_rsp.waitrequest !== 1'b0);
      rd = avm_rsp.readdata;
      avm_req.read <= 1'b0;
      avm_req.write <= 1'b0;
   endtask

   task automatic wr(input logic [8:0] d);
      dcsf_far_end_inst.pin_cycle(1'b0, 1'b0, 1'b1, 1'b1, d);
   endtask

   task automatic rdp(input logic ren_n, input logic ld_n, input logic rt_n);
      dcsf_far_end_inst.pin_cycle(1'b1, ren_n, ld_n, rt_n, 9'h000);
   endtask

   task automatic stop_test();
      $display("compares %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // hang guard, far beyond the fewer than one thousand cycles the tests need
   initial begin
      repeat (30000) @(posedge clk_i);
      num_errors++;
      stop_test();
   end

   // main sequence
   initial begin
      resetn_i = 1'b0;
      avm_req = '0;
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      dcsf_far_end_inst.master_reset(1'b0, 1'b1);
      check(32'(dout), 32'h0);
      check(32'(flags.empty_flag_n), 32'h0);
      check(32'(flags.full_flag_n), 32'h1);
      avm(1'b0, 2'h1, 32'h0);
      check(rd, off_word(15'h03FF, 15'h03FF));
      avm(1'b0, 2'h3, 32'h0);
      check(rd, 32'h0);
      avm(1'b0, 2'h2, 32'h0);
      check(rd & 32'h3, 32'h2);
      $display("reset test done");
      for (i = 0; i < 6; i++) begin
         q.push_back(9'($random(seed)));
         wr(q[i]);
      end
      check(32'(dout), 32'h0);
      check(32'(flags.empty_flag_n), 32'h1);
      check(32'(flags.almost_empty_flag_n), 32'h0);
      avm(1'b0, 2'h0, 32'h0);
      check(32'(rd[14:0]), 32'h6);
      for (i = 0; i < 3; i++) begin
         rdp(1'b0, 1'b1, 1'b1);
         check(32'(dout), 32'(q[i]));
      end
      rdp(1'b1, 1'b1, 1'b0);
      check(32'(flags.empty_flag_n), 32'h0);
      for (i = 0; i < 6; i++) begin
         rdp(1'b0, 1'b1, 1'b1);
         check(32'(dout), 32'(q[i]));
      end
      rdp(1'b0, 1'b1, 1'b1);
      check(32'(dout), 32'(q[5]));
      check(32'(flags.empty_flag_n), 32'h0);
      $display("stream test done");
      dcsf_far_end_inst.set_oe(1'b1);
      repeat (5) @(posedge clk_i);
      check(32'(dout_oe_n), 32'h1);
      dcsf_far_end_inst.set_oe(1'b0);
      repeat (5) @(posedge clk_i);
      check(32'(dout_oe_n), 32'h0);
      $display("output enable test done");
      // almost full threshold at six words, 16378 below the full boundary
      avm(1'b1, 2'h1, off_word(15'h0005, 15'h3FFA));
      for (i = 0; i < 6; i++) wr(9'($random(seed)));
      check(32'(flags.almost_empty_flag_n), 32'h1);
      check(32'(flags.almost_full_flag_n), 32'h0);
      check(32'(flags.half_full_flag_n), 32'h1);
      dcsf_far_end_inst.partial_reset();
      check(32'(flags.empty_flag_n), 32'h0);
      avm(1'b0, 2'h1, 32'h0);
      check(rd, off_word(15'h0005, 15'h3FFA));
      exp_off = '{9'h005, 9'h000, 9'h1FA, 9'h01F};
      for (i = 0; i < 4; i++) begin
         rdp(1'b0, 1'b0, 1'b1);
         check(32'(dout), 32'(exp_off[i]));
      end
      $display("offset and partial reset test done");
      dcsf_far_end_inst.master_reset(1'b0, 1'b0);
      avm(1'b0, 2'h1, 32'h0);
      check(rd, off_word(15'h007F, 15'h007F));
      for (i = 0; i < 4; i++) begin
         w[i] = 9'($random(seed));
         dcsf_far_end_inst.pin_cycle(1'b0, 1'b0, 1'b0, 1'b1, w[i]);
      end
      avm(1'b0, 2'h1, 32'h0);
      check(rd, off_word({w[1][5:0], w[0]}, {w[3][5:0], w[2]}));
      dcsf_far_end_inst.master_reset(1'b0, 1'b1);
      v = $random(seed);
      for (i = 0; i < 30; i++) dcsf_far_end_inst.pin_cycle(1'b0, 1'b1, 1'b0, 1'b0, 9'(v[i]));
      avm(1'b0, 2'h1, 32'h0);
      check(rd, off_word(v[14:0], v[29:15]));
      $display("offset load test done");
      dcsf_far_end_inst.master_reset(1'b1, 1'b1);
      avm(1'b0, 2'h2, 32'h0);
      check(rd & 32'h1, 32'h1);
      w[0] = 9'($random(seed));
      wr(w[0]);
      rdp(1'b1, 1'b1, 1'b1);
      rdp(1'b1, 1'b1, 1'b1);
      check(32'(dout), 32'(w[0]));
      check(32'(flags.empty_flag_n), 32'h0);
      w[1] = 9'($random(seed));
      wr(w[1]);
      rdp(1'b0, 1'b1, 1'b1);
      check(32'(dout), 32'(w[1]));
      $display("fall through test done");
      i = 0;
      while (standby !== 1'b1 && i < 200) begin
         @(negedge clk_i);
         i++;
      end
      check(32'(standby), 32'h1);
      $display("standby test done");
      stop_test();
   end
endmodule
